// ===== bench/pbc_assertions.sv
// Checker for the basic control and status register block.
// Assumes binding to pbc_regs; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pbc_assertions (
    input wire logic        aclk,          // Clock
    input wire logic        aresetn,       // Reset, low
    input wire logic        s_awvalid,     // AW valid
    input wire logic        s_awready,     // AW ready
    input wire logic        s_wvalid,      // W valid
    input wire logic        s_wready,      // W ready
    input wire logic        s_bvalid,      // B valid
    input wire logic        s_arvalid,     // AR valid
    input wire logic        s_arready,     // AR ready
    input wire logic        s_rvalid,      // R valid
    input wire logic        s_rready,      // R ready
    input wire logic [31:0] s_rdata,       // Read data
    input wire logic        mac_rx_dv,     // MAC rx valid
    input wire logic [3:0]  mac_rxd,       // MAC rx data
    input wire logic        mac_rx_oe_n,   // Rx enable, low drives
    input wire logic        core_tx_en,    // Line tx enable
    input wire logic        core_link,     // Raw link
    input wire logic        link_up,       // Link indication
    input wire logic        power_down,    // Power-down
    input wire logic        digital_reset  // Soft reset active
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Counts the current run of soft reset cycles
    logic [7:0] srst_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || !digital_reset) srst_cnt <= 8'h00;
        else srst_cnt <= srst_cnt + 8'h01;
    end

    chk_srst_len: assert property ($fell(digital_reset) |-> srst_cnt == 8'h28)
        else $error("soft reset length wrong");
    chk_srst_max: assert property (srst_cnt <= 8'h28)
        else $error("soft reset too long");
    chk_srst_link: assert property (digital_reset |=> !link_up)
        else $error("link up during soft reset");
    chk_srst_tx: assert property (digital_reset && $past(digital_reset) |-> !core_tx_en)
        else $error("transmit during soft reset");
    chk_pd_link: assert property (power_down |=> !link_up)
        else $error("link up in power-down");
    chk_pd_oe: assert property (power_down |-> mac_rx_oe_n)
        else $error("receive driven in power-down");
    chk_iso_quiet: assert property (mac_rx_oe_n && $past(mac_rx_oe_n) |-> !mac_rx_dv && mac_rxd == 4'h0)
        else $error("receive active while isolated");
    chk_link_src: assert property (link_up |-> $past(core_link))
        else $error("link up without raw link");
    chk_rd_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read not answered");
    chk_rd_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data not held");
    chk_rd_upper: assert property (s_rvalid |-> s_rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    chk_wr_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid)
        else $error("write not answered");

    // Main scenarios seen
    cover property ($fell(digital_reset));
    cover property (link_up);
    cover property (power_down);
endmodule // pbc_assertions

bind pbc_regs pbc_assertions u_pbc_assertions (.aclk, .aresetn, .s_awvalid, .s_awready,
    .s_wvalid, .s_wready, .s_bvalid, .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata,
    .mac_rx_dv, .mac_rxd, .mac_rx_oe_n, .core_tx_en, .core_link, .link_up, .power_down,
    .digital_reset);
`default_nettype wire

// ===== bench/pbc_far_model.sv
// Far side model: MAC transmit stream and line-side receive stream.
// Assumes the bench gates traffic with run; data changes every cycle.
`timescale 1ns/1ps
`default_nettype none
module pbc_far_model (
    input  wire logic       aclk,   // Clock
    input  wire logic       run,    // Frame in progress
    output logic            tx_en,  // MAC tx enable
    output logic            tx_er,  // MAC tx error
    output logic [3:0]      txd,    // MAC tx nibble
    output logic            rx_dv,  // Line rx valid
    output logic            rx_er,  // Line rx error
    output logic [3:0]      rxd     // Line rx nibble
);
    logic [3:0] nib = 4'h0;
    // Counting nibble so every cycle carries a new value
    always @(posedge aclk) nib <= nib + 4'h1;
    // Line side sends the inverse so both sources differ
    assign tx_en = run;
    assign tx_er = 1'b0;
    assign txd   = nib;
    assign rx_dv = run;
    assign rx_er = 1'b0;
    assign rxd   = ~nib;
endmodule // pbc_far_model
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for pbc_regs over AXI4-Lite with a far side model.
// Assumes a 40 MHz aclk and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "pbc_defs.svh"
module tb;
    import pbc_pkg::*;
    typedef struct {logic [15:0] wv, rv, st; logic oen, lnk;} pbc_row_s;
    logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, pin_drv = 1'b1;
    logic core_link = 1'b0, core_jabber = 1'b0, int_pin_o, int_pin_oe_n, int_pin_i;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq, link_up;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [3:0] s_wstrb = 4'hf;
    logic rd_slow = 1'b0;
    logic [31:0] s_wdata = 32'h0, s_rdata, rd_d;
    logic [1:0] s_bresp, s_rresp, rsp;
    logic mac_tx_en, mac_tx_er, mac_rx_dv, mac_rx_er, mac_rx_oe_n, core_rx_dv, core_rx_er;
    logic core_tx_en, core_tx_er, power_down, digital_reset;
    logic [3:0] mac_txd, mac_rxd, core_rxd, core_txd;
    int fails = 0, comparisons = 0, n;
    pbc_row_s rows [6] = '{'{16'h0000, 16'h2100, 16'h0065, 1'b0, 1'b1},
        '{16'h4000, 16'h6100, 16'h0061, 1'b0, 1'b0}, '{16'h0800, 16'h2900, 16'h0061, 1'b1, 1'b0},
        '{16'h0400, 16'h2500, 16'h0065, 1'b1, 1'b1}, '{16'h0080, 16'h2180, 16'h0065, 1'b0, 1'b1},
        '{16'h127f, 16'h2100, 16'h0065, 1'b0, 1'b1}};

    always #12.5 aclk = ~aclk;
    // Open-drain pin with pull-up: low when either side pulls
    assign int_pin_i = pin_drv & (int_pin_oe_n | int_pin_o);

    pbc_regs u_pbc_regs (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .mac_tx_en,
        .mac_tx_er, .mac_txd, .mac_rx_dv, .mac_rx_er, .mac_rxd, .mac_rx_oe_n, .core_rx_dv,
        .core_rx_er, .core_rxd, .core_tx_en, .core_tx_er, .core_txd, .core_link, .core_jabber,
        .link_up, .power_down, .digital_reset, .int_pin_i, .int_pin_o, .int_pin_oe_n, .irq);
    pbc_far_model u_pbc_far_model (.aclk, .run, .tx_en(mac_tx_en), .tx_er(mac_tx_er),
        .txd(mac_txd), .rx_dv(core_rx_dv), .rx_er(core_rx_er), .rxd(core_rxd));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Write with both channels offered together, wait for the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        r = s_bresp;
        s_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= !rd_slow;
        // A slow read raises rready only once rvalid is seen, so the hold is exercised
        do begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid === 1'b1 && s_rready !== 1'b1) s_rready <= 1'b1;
        end while (s_rvalid !== 1'b1 || s_rready !== 1'b1);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
    endtask
    task automatic wrc(input logic [7:0] a, input logic [15:0] d);
        wr(a, {16'h0, d}, rsp);
        chk("bresp", 32'h0, {30'h0, rsp});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        rd(a, rd_d, rsp);
        chk($sformatf("reg %h", a), {`PBC_RESP_OKAY, 14'h0, e}, {rsp, rd_d[29:0]});
    endtask
    task automatic reset_dut;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic summarize;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog: whole run is a few hundred cycles
    initial begin
        #(25 * 20000);
        fails++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(8'h00, 16'h2100);
        rdc(8'h04, 16'h0061);
        wrc(8'h44, 16'h0000);
        core_link <= 1'b1;
        run <= 1'b1;
        $display("test reset done");
        // Control modes; receive path compared against the far side stream
        foreach (rows[i]) begin
            wrc(8'h00, rows[i].wv);
            rdc(8'h00, rows[i].rv);
            rdc(8'h04, rows[i].st);
            @(negedge aclk);
            chk("oe_n", {31'h0, rows[i].oen}, {31'h0, mac_rx_oe_n});
            chk("link_up", {31'h0, rows[i].lnk}, {31'h0, link_up});
            chk("core_tx_en", {31'h0, !rows[i].oen && !rows[i].wv[14]}, {31'h0, core_tx_en});
            chk("rx_dv", {31'h0, !rows[i].oen}, {31'h0, mac_rx_dv});
            if (!rows[i].oen && !rows[i].wv[14])
                chk("core_txd", {28'h0, mac_txd - 4'h1}, {28'h0, core_txd});
            if (rows[i].wv[14])
                chk("loop_rxd", {28'h0, mac_txd - 4'h1}, {28'h0, mac_rxd});
            else if (!rows[i].oen)
                chk("rxd", {28'h0, ~(mac_txd - 4'h1)}, {28'h0, mac_rxd});
        end
        $display("test rows done");
        // Lower strobe only: power-down and isolate in the upper byte stay clear
        @(posedge aclk);
        s_wstrb <= 4'h1;
        wrc(8'h00, 16'h0c80);
        s_wstrb <= 4'hf;
        rdc(8'h00, 16'h2180);
        wrc(8'h00, 16'h0000);
        $display("test strobe done");
        // Jabber event, mask and write-one-to-clear
        core_jabber <= 1'b1;
        rdc(8'h04, 16'h0067);
        chk("irq masked", 32'h0, {31'h0, irq});
        wrc(8'h44, 16'h0002);
        chk("irq on", 32'h1, {31'h0, irq});
        chk("int pin oe_n", 32'h0, {31'h0, int_pin_oe_n});
        wrc(8'h40, 16'h0002);
        chk("irq cleared", 32'h0, {31'h0, irq});
        core_jabber <= 1'b0;
        rdc(8'h04, 16'h0065);
        wrc(8'h04, 16'hffff);
        rdc(8'h04, 16'h0065);
        $display("test irq done");
        // Pin used as power-down input
        wrc(8'h48, 16'h0001);
        pin_drv <= 1'b0;
        rdc(8'h00, 16'h2900);
        chk("pin pd", 32'h1, {31'h0, power_down});
        pin_drv <= 1'b1;
        wrc(8'h00, 16'h0000);
        rdc(8'h00, 16'h2100);
        chk("pd off", 32'h0, {31'h0, power_down});
        $display("test pin done");
        // Soft reset clears control only and raises the done event
        wrc(8'h44, 16'h0004);
        wrc(8'h00, 16'h4480);
        wrc(8'h00, 16'hc480);
        rdc(8'h00, 16'ha100);
        for (n = 0; n < 100 && digital_reset !== 1'b0; n++) @(posedge aclk);
        chk("srst end", 32'h0, {31'h0, digital_reset});
        rdc(8'h00, 16'h2100);
        rd_slow = 1'b1;
        rdc(8'h48, 16'h0001);
        rd_slow = 1'b0;
        chk("irq done", 32'h1, {31'h0, irq});
        $display("test soft reset done");
        // Unmapped and misaligned places
        rd(8'h80, rd_d, rsp);
        chk("unmapped rd", {`PBC_RESP_DECERR, 30'h0}, {rsp, rd_d[29:0]});
        wr(8'h80, 32'h1, rsp);
        chk("unmapped wr", {30'h0, `PBC_RESP_DECERR}, {30'h0, rsp});
        rd(8'h02, rd_d, rsp);
        chk("misaligned", {30'h0, `PBC_RESP_DECERR}, {30'h0, rsp});
        // Second reset in mid-run
        wrc(8'h00, 16'h4400);
        reset_dut();
        rdc(8'h00, 16'h2100);
        $display("test reset again done");
        summarize();
    end
endmodule // tb
`default_nettype wire

// ===== rtl/pbc_defs.svh
// Constants for the basic control and status register block of the PHY.
// Assumes a 40 MHz aclk and a 32-bit AXI4-Lite register port.
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

// Register indices; byte address is four times the index
`define PBC_IDX_CTRL     6'h00
`define PBC_IDX_STAT     6'h01
`define PBC_IDX_IRQ_ST   6'h10
`define PBC_IDX_IRQ_MSK  6'h11
`define PBC_IDX_PIN_CFG  6'h12
`define PBC_IDX_SRST_TOP 6'h0f

// Reset values and fixed status content
`define PBC_CTRL_RST     16'h2100
`define PBC_STAT_FIXED   16'h0061

// Control field positions
`define PBC_B_SRST       15
`define PBC_B_LOOP       14
`define PBC_B_PD         11
`define PBC_B_ISO        10
`define PBC_B_RSV7       7

// Status field positions
`define PBC_B_LINK       2
`define PBC_B_JAB        1

// Interrupt event positions
`define PBC_EV_LINK      0
`define PBC_EV_JAB       1
`define PBC_EV_RSTDONE   2
`define PBC_EV_W         3

// Soft reset length
`define PBC_CLK_MHZ      40
`define PBC_SRST_NS      1000
`define PBC_SRST_CYC     ((`PBC_SRST_NS * `PBC_CLK_MHZ + 999) / 1000)

// AXI responses
`define PBC_RESP_OKAY    2'h0
`define PBC_RESP_DECERR  2'h3

`endif

// ===== rtl/pbc_pkg.sv
// Types for the basic control and status register block.
// Assumes pbc_defs.svh supplies the field widths used here.
`include "pbc_defs.svh"

package pbc_pkg;

    // Phase of the digital logic
    typedef enum logic [1:0] {
        PBC_RUN  = 2'b01,
        PBC_SRST = 2'b10
    } pbc_phase_e;

    // Whole state of the block
    typedef struct packed {
        logic                   aw_ok;
        logic [5:0]             aw_idx;
        logic                   w_ok;
        logic [15:0]            w_data;
        logic [1:0]             w_strb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [15:0]            rdata;
        logic [1:0]             rresp;
        pbc_phase_e             phase;
        logic [7:0]             rst_cnt;
        logic                   loop_en;
        logic                   pd_bit;
        logic                   iso_en;
        logic                   rsv7;
        logic                   pin_pd_mode;
        logic [`PBC_EV_W-1:0]   irq_st;
        logic [`PBC_EV_W-1:0]   irq_msk;
        logic                   link_q;
        logic                   jab_q;
        logic                   rx_dv;
        logic                   rx_er;
        logic [3:0]             rxd;
        logic                   tx_en;
        logic                   tx_er;
        logic [3:0]             txd;
    } pbc_state_s;

endpackage

// ===== rtl/pbc_regs.sv
// Basic control and status registers of a 100 Mbit/s single-pair PHY,
// with MAC-side loopback, power-down, isolate and interrupt gathering.
// Assumes AXI4-Lite master on aclk and MAC/core signals synchronous to aclk.
//
// Behaviour
// - Control bit 15 write of one resets digital logic and registers 0x0-0xF.
// - Control bit 14 loops MAC transmit data back onto MAC receive outputs.
// - No link-up indication while MAC-side loopback is enabled.
// - Control bit 13 reads one: speed is always 100 Mbit/s.
// - Control bit 12 reads zero: no automatic negotiation.
// - Control bit 11 powers down; register access and interrupt gathering keep working.
// - Low pin in power-down mode sets bit 11; effective power-down is pin OR bit.
// - Control bit 10 isolates the MAC data interface; management still works.
// - Control bit 8 reads one: full duplex.
// - Control register resets to 0x2100.
// - Status register reads 0x0061 after reset; ability bits read zero.
// - Status bit 6 reads one: preamble-less management frames accepted.
// - Status bit 2 shows link state, one when up.
// - Status bit 1 reads one while jabber is detected, else zero.
`timescale 1ns/1ps
`default_nettype none
`include "pbc_defs.svh"

module pbc_regs
    import pbc_pkg::*;
(
    input  wire logic        aclk,          // 40 MHz clock
    input  wire logic        aresetn,       // Synchronous reset, low
    input  wire logic [7:0]  s_awaddr,      // Write address
    input  wire logic        s_awvalid,     // Write address valid
    output logic             s_awready,     // Write address ready
    input  wire logic [31:0] s_wdata,       // Write data
    input  wire logic [3:0]  s_wstrb,       // Write strobes
    input  wire logic        s_wvalid,      // Write data valid
    output logic             s_wready,      // Write data ready
    output logic [1:0]       s_bresp,       // Write response
    output logic             s_bvalid,      // Write response valid
    input  wire logic        s_bready,      // Write response ready
    input  wire logic [7:0]  s_araddr,      // Read address
    input  wire logic        s_arvalid,     // Read address valid
    output logic             s_arready,     // Read address ready
    output logic [31:0]      s_rdata,       // Read data
    output logic [1:0]       s_rresp,       // Read response
    output logic             s_rvalid,      // Read data valid
    input  wire logic        s_rready,      // Read data ready
    input  wire logic        mac_tx_en,     // MAC transmit enable
    input  wire logic        mac_tx_er,     // MAC transmit error
    input  wire logic [3:0]  mac_txd,       // MAC transmit data
    output logic             mac_rx_dv,     // MAC receive data valid
    output logic             mac_rx_er,     // MAC receive error
    output logic [3:0]       mac_rxd,       // MAC receive data
    output logic             mac_rx_oe_n,   // Receive outputs enable, low drives
    input  wire logic        core_rx_dv,    // Line-side receive valid
    input  wire logic        core_rx_er,    // Line-side receive error
    input  wire logic [3:0]  core_rxd,      // Line-side receive data
    output logic             core_tx_en,    // Transmit enable to line side
    output logic             core_tx_er,    // Transmit error to line side
    output logic [3:0]       core_txd,      // Transmit data to line side
    input  wire logic        core_link,     // Raw link from line side
    input  wire logic        core_jabber,   // Jabber detect level
    output logic             link_up,       // Link-up indication
    output logic             power_down,    // Effective power-down
    output logic             digital_reset, // Digital logic held in reset
    input  wire logic        int_pin_i,     // Interrupt/power-down pin level
    output logic             int_pin_o,     // Pin output value
    output logic             int_pin_oe_n,  // Pin enable, low drives
    output logic             irq            // Level interrupt
);

    pbc_state_s q;
    pbc_state_s next_q;

    logic        pin_pd;
    logic        pd_eff;
    logic        lnk;
    logic        in_srst;
    logic        wr_fire;
    logic        rd_fire;
    logic [15:0] wmask;
    logic [15:0] ctrl_rd;
    logic [15:0] stat_rd;
    logic [15:0] wr_cur;
    logic [15:0] wr_new;
    logic [`PBC_EV_W-1:0] ev;

    // Control reset word; writable bits take their power-on and soft reset values here
    localparam logic [15:0] ctrl_rst_val = `PBC_CTRL_RST;

    // Derived levels
    assign in_srst = (q.phase == PBC_SRST);
    assign pin_pd  = q.pin_pd_mode & ~int_pin_i;
    assign pd_eff  = q.pd_bit | pin_pd;
    assign lnk     = core_link & ~q.loop_en & ~pd_eff & ~in_srst;
    assign wr_fire = q.aw_ok & q.w_ok & ~q.bvalid;
    assign rd_fire = s_arvalid & ~q.rvalid;
    assign wmask   = {{8{q.w_strb[1]}}, {8{q.w_strb[0]}}};

    // Control read view; fixed bits come from the reset value
    always_comb begin
        ctrl_rd = `PBC_CTRL_RST;
        ctrl_rd[`PBC_B_SRST] = in_srst;
        ctrl_rd[`PBC_B_LOOP] = q.loop_en;
        ctrl_rd[`PBC_B_PD]   = q.pd_bit;
        ctrl_rd[`PBC_B_ISO]  = q.iso_en;
        ctrl_rd[`PBC_B_RSV7] = q.rsv7;
    end

    // Status read view
    always_comb begin
        stat_rd = `PBC_STAT_FIXED;
        stat_rd[`PBC_B_LINK] = lnk;
        stat_rd[`PBC_B_JAB]  = core_jabber;
    end

    // Current value of the register being written
    always_comb begin
        wr_cur = 16'h0000;
        unique case (q.aw_idx)
            `PBC_IDX_CTRL:    wr_cur = ctrl_rd;
            `PBC_IDX_PIN_CFG: wr_cur = {15'h0000, q.pin_pd_mode};
            default:          wr_cur = 16'h0000;
        endcase
        wr_new = (wr_cur & ~wmask) | (q.w_data & wmask);
    end

    // Interrupt events
    always_comb begin
        ev = '0;
        ev[`PBC_EV_LINK]    = lnk ^ q.link_q;
        ev[`PBC_EV_JAB]     = core_jabber & ~q.jab_q;
        ev[`PBC_EV_RSTDONE] = in_srst && (q.rst_cnt == 8'(`PBC_SRST_CYC - 1));
    end

    // Next-state logic
    always_comb begin
        next_q = q;
        next_q.link_q = lnk;
        next_q.jab_q  = core_jabber;

        // Write address and data taken independently
        if (s_awvalid && !q.aw_ok && !q.bvalid) begin
            next_q.aw_ok  = 1'b1;
            next_q.aw_idx = (s_awaddr[1:0] == 2'h0) ? s_awaddr[7:2] : 6'h3f;
        end
        if (s_wvalid && !q.w_ok && !q.bvalid) begin
            next_q.w_ok   = 1'b1;
            next_q.w_data = s_wdata[15:0];
            next_q.w_strb = s_wstrb[1:0];
        end
        if (q.bvalid && s_bready) begin
            next_q.bvalid = 1'b0;
        end

        // Register write
        if (wr_fire) begin
            next_q.aw_ok  = 1'b0;
            next_q.w_ok   = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp  = `PBC_RESP_OKAY;
            unique case (q.aw_idx)
                `PBC_IDX_CTRL: begin
                    // Writes during soft reset are answered but dropped
                    if (!in_srst) begin
                        next_q.loop_en = wr_new[`PBC_B_LOOP];
                        next_q.pd_bit  = wr_new[`PBC_B_PD];
                        next_q.iso_en  = wr_new[`PBC_B_ISO];
                        next_q.rsv7    = wr_new[`PBC_B_RSV7];
                        if (wr_new[`PBC_B_SRST] && wmask[`PBC_B_SRST]) begin
                            next_q.phase   = PBC_SRST;
                            next_q.rst_cnt = 8'h00;
                        end
                    end
                end
                `PBC_IDX_STAT: begin
                end
                `PBC_IDX_IRQ_ST: begin
                    next_q.irq_st = q.irq_st & ~(q.w_data[`PBC_EV_W-1:0]
                                                 & wmask[`PBC_EV_W-1:0]);
                end
                `PBC_IDX_IRQ_MSK: begin
                    next_q.irq_msk = (q.irq_msk & ~wmask[`PBC_EV_W-1:0])
                                   | (q.w_data[`PBC_EV_W-1:0] & wmask[`PBC_EV_W-1:0]);
                end
                `PBC_IDX_PIN_CFG: begin
                    next_q.pin_pd_mode = wr_new[0];
                end
                default: begin
                    next_q.bresp = `PBC_RESP_DECERR;
                end
            endcase
        end

        // Events set sticky bits; a set wins over a clear in the same cycle
        next_q.irq_st = next_q.irq_st | ev;

        // Soft reset sequence restores the low register set
        if (in_srst) begin
            next_q.loop_en = ctrl_rst_val[`PBC_B_LOOP];
            next_q.pd_bit  = ctrl_rst_val[`PBC_B_PD];
            next_q.iso_en  = ctrl_rst_val[`PBC_B_ISO];
            next_q.rsv7    = ctrl_rst_val[`PBC_B_RSV7];
            next_q.rst_cnt = q.rst_cnt + 8'h01;
            if (ev[`PBC_EV_RSTDONE]) begin
                next_q.phase = PBC_RUN;
            end
        end

        // Pin in power-down mode sets the bit, winning over a write
        if (pin_pd) begin
            next_q.pd_bit = 1'b1;
        end

        // Register read
        if (q.rvalid && s_rready) begin
            next_q.rvalid = 1'b0;
        end
        if (rd_fire) begin
            next_q.rvalid = 1'b1;
            next_q.rresp  = `PBC_RESP_OKAY;
            next_q.rdata  = 16'h0000;
            if (s_araddr[1:0] != 2'h0) begin
                next_q.rresp = `PBC_RESP_DECERR;
            end else begin
                unique case (s_araddr[7:2])
                    `PBC_IDX_CTRL:    next_q.rdata = ctrl_rd;
                    `PBC_IDX_STAT:    next_q.rdata = stat_rd;
                    `PBC_IDX_IRQ_ST:  next_q.rdata = {13'h0000, q.irq_st};
                    `PBC_IDX_IRQ_MSK: next_q.rdata = {13'h0000, q.irq_msk};
                    `PBC_IDX_PIN_CFG: next_q.rdata = {15'h0000, q.pin_pd_mode};
                    default:          next_q.rresp = `PBC_RESP_DECERR;
                endcase
            end
        end

        // MAC data path: loopback, isolate and power-down
        next_q.rx_dv = 1'b0;
        next_q.rx_er = 1'b0;
        next_q.rxd   = 4'h0;
        next_q.tx_en = 1'b0;
        next_q.tx_er = 1'b0;
        next_q.txd   = 4'h0;
        if (!pd_eff && !in_srst && !q.iso_en) begin
            if (q.loop_en) begin
                next_q.rx_dv = mac_tx_en;
                next_q.rx_er = mac_tx_er;
                next_q.rxd   = mac_txd;
            end else begin
                next_q.rx_dv = core_rx_dv;
                next_q.rx_er = core_rx_er;
                next_q.rxd   = core_rxd;
                next_q.tx_en = mac_tx_en;
                next_q.tx_er = mac_tx_er;
                next_q.txd   = mac_txd;
            end
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q             <= '0;
            q.phase       <= PBC_RUN;
            q.loop_en     <= ctrl_rst_val[`PBC_B_LOOP];
            q.pd_bit      <= ctrl_rst_val[`PBC_B_PD];
            q.iso_en      <= ctrl_rst_val[`PBC_B_ISO];
            q.rsv7        <= ctrl_rst_val[`PBC_B_RSV7];
            q.bresp       <= `PBC_RESP_OKAY;
            q.rresp       <= `PBC_RESP_OKAY;
        end else begin
            q <= next_q;
        end
    end

    // Outputs
    assign s_awready     = ~q.aw_ok & ~q.bvalid;
    assign s_wready      = ~q.w_ok & ~q.bvalid;
    assign s_bvalid      = q.bvalid;
    assign s_bresp       = q.bresp;
    assign s_arready     = ~q.rvalid;
    assign s_rvalid      = q.rvalid;
    assign s_rresp       = q.rresp;
    assign s_rdata       = {16'h0000, q.rdata};
    assign mac_rx_dv     = q.rx_dv;
    assign mac_rx_er     = q.rx_er;
    assign mac_rxd       = q.rxd;
    // Receive pins released while isolated or powered down
    assign mac_rx_oe_n   = q.iso_en | pd_eff;
    assign core_tx_en    = q.tx_en;
    assign core_tx_er    = q.tx_er;
    assign core_txd      = q.txd;
    assign link_up       = q.link_q;
    assign power_down    = pd_eff;
    assign digital_reset = in_srst;
    assign irq           = |(q.irq_st & q.irq_msk);
    // Pin acts as open-drain interrupt unless set up for power-down
    assign int_pin_o     = 1'b0;
    assign int_pin_oe_n  = q.pin_pd_mode | ~irq;

endmodule // pbc_regs

`default_nettype wire
